// File: design/pmr_pkg.sv
// package for the power mode and reset sequencer
package pmr_pkg;
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned POR_HOLD_MS    = 128;
    localparam int unsigned PLL_LOCK_US    = 1000;
    localparam int unsigned OSC_START_MS   = 150;
    localparam int unsigned POR_CYCLES     = POR_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned PLL_CYCLES     = PLL_LOCK_US * (CLK_HZ / 1000000);
    localparam int unsigned OSC_CYCLES     = OSC_START_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W          = 32;
    localparam logic [1:0]  IDLE_BIT_POS   = 2'h0;
    localparam logic [1:0]  PD_BIT_POS     = 2'h1;
    localparam logic [7:0]  PLL_LOCK_POS   = 8'h06;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 32'h00000000;

    typedef enum logic [1:0] {
        PMR_NORMAL = 2'b00,
        PMR_IDLE   = 2'b01,
        PMR_PDOWN  = 2'b10,
        PMR_RESET  = 2'b11
    } pmr_mode_t;

    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic pll_en;
        logic osc_en;
        logic interval_counter_en;
    } pmr_clk_t;

    typedef struct packed {
        logic ale;
        logic program_store_strobe;
        logic hold_ports;
        logic dac_oe;
    } pmr_pin_t;

    typedef struct packed {
        pmr_mode_t       mode;
        logic [CNT_W-1:0] por_cnt;
        logic [CNT_W-1:0] lock_cnt;
        logic            core_reset;
        logic            pll_locked;
        logic            wake_pulse;
        pmr_clk_t        clk;
        pmr_pin_t        pin;
        logic [1:0]      sync_rst;
        logic [1:0]      sync_por;
    } pmr_state_t;
endpackage

// File: design/pmr_sequencer.sv
// power mode and reset sequencer: mode machine, clock gates, strobes and reset timers
module pmr_sequencer #(
    parameter logic [31:0] POR_CYCLES_P  = pmr_pkg::POR_CYCLES,
    parameter logic [31:0] PLL_CYCLES_P  = pmr_pkg::PLL_CYCLES,
    parameter logic [31:0] OSC_CYCLES_P  = pmr_pkg::OSC_CYCLES
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              supply_ok,
    input  wire logic              reset_pin,
    input  wire logic              idle_req,
    input  wire logic              powerdown_req,
    input  wire logic              oscillator_powerdown_bit,
    input  wire logic              serial_wake_enable,
    input  wire logic              ext_int_zero_wake_enable,
    input  wire logic              any_enabled_irq,
    input  wire logic              interval_counter_irq,
    input  wire logic              interval_counter_enable,
    input  wire logic              spi_irq_enabled,
    input  wire logic              external_interrupt_zero_enabled,
    output logic [1:0]             mode,
    output pmr_pkg::pmr_clk_t      clk_ctl,
    output pmr_pkg::pmr_pin_t      pin_ctl,
    output logic                   core_reset,
    output logic [7:0]             pll_control_reg,
    output logic                   wake_pulse
);
    pmr_pkg::pmr_state_t st_ff;
    pmr_pkg::pmr_state_t nxt_st;
    logic                rst_s;
    logic                sup_s;
    logic                wake;

    assign rst_s = st_ff.sync_rst[1];
    assign sup_s = st_ff.sync_por[1];

    always_comb begin
        nxt_st            = st_ff;
        wake              = 1'b0;
        nxt_st.wake_pulse = 1'b0;
        nxt_st.sync_rst   = {st_ff.sync_rst[0], reset_pin};
        nxt_st.sync_por   = {st_ff.sync_por[0], supply_ok};
        if (!sup_s) begin
            // supply detector asserts below threshold, stays low until below 1 V on fall
            nxt_st.mode       = pmr_pkg::PMR_RESET;
            nxt_st.por_cnt    = POR_CYCLES_P;
            nxt_st.core_reset = 1'b1;
        end else if (rst_s) begin
            nxt_st.mode       = pmr_pkg::PMR_RESET;
            nxt_st.por_cnt    = pmr_pkg::CNT_ZERO;
            nxt_st.core_reset = 1'b1;
        end else begin
            case (st_ff.mode)
                pmr_pkg::PMR_RESET: begin
                    if (st_ff.por_cnt != pmr_pkg::CNT_ZERO) begin
                        nxt_st.por_cnt = st_ff.por_cnt - 32'h00000001;
                    end else begin
                        nxt_st.mode       = pmr_pkg::PMR_NORMAL;
                        nxt_st.core_reset = 1'b0;
                        nxt_st.lock_cnt   = PLL_CYCLES_P;
                        nxt_st.pll_locked = 1'b0;
                    end
                end
                pmr_pkg::PMR_NORMAL: begin
                    if (powerdown_req) begin
                        nxt_st.mode = pmr_pkg::PMR_PDOWN;
                    end else if (idle_req) begin
                        nxt_st.mode = pmr_pkg::PMR_IDLE;
                    end
                end
                pmr_pkg::PMR_IDLE: begin
                    if (any_enabled_irq) begin
                        nxt_st.mode = pmr_pkg::PMR_NORMAL;
                        wake        = 1'b1;
                    end
                end
                pmr_pkg::PMR_PDOWN: begin
                    if ((interval_counter_irq && interval_counter_enable && !oscillator_powerdown_bit)
                        || (serial_wake_enable && spi_irq_enabled)
                        || (ext_int_zero_wake_enable && external_interrupt_zero_enabled)) begin
                        nxt_st.mode       = pmr_pkg::PMR_NORMAL;
                        wake              = 1'b1;
                        nxt_st.pll_locked = 1'b0;
                        nxt_st.lock_cnt   = oscillator_powerdown_bit ?
                                            OSC_CYCLES_P + PLL_CYCLES_P : PLL_CYCLES_P;
                    end
                end
                default: nxt_st.mode = pmr_pkg::PMR_RESET;
            endcase
            nxt_st.wake_pulse = wake;
            if (st_ff.mode == pmr_pkg::PMR_NORMAL && !st_ff.pll_locked) begin
                if (st_ff.lock_cnt != pmr_pkg::CNT_ZERO) begin
                    nxt_st.lock_cnt = st_ff.lock_cnt - 32'h00000001;
                end else begin
                    nxt_st.pll_locked = 1'b1;
                end
            end
        end
        // clock and pin controls follow the next mode
        nxt_st.clk.core_clk_en   = (nxt_st.mode == pmr_pkg::PMR_NORMAL);
        nxt_st.clk.periph_clk_en = (nxt_st.mode != pmr_pkg::PMR_PDOWN);
        nxt_st.clk.pll_en        = (nxt_st.mode != pmr_pkg::PMR_PDOWN);
        nxt_st.clk.osc_en        = (nxt_st.mode != pmr_pkg::PMR_PDOWN) || !oscillator_powerdown_bit;
        nxt_st.clk.interval_counter_en = interval_counter_enable && nxt_st.clk.osc_en;
        nxt_st.pin.hold_ports    = (nxt_st.mode == pmr_pkg::PMR_IDLE) ||
                                   (nxt_st.mode == pmr_pkg::PMR_PDOWN);
        nxt_st.pin.dac_oe        = (nxt_st.mode != pmr_pkg::PMR_PDOWN);
        nxt_st.pin.ale           = (nxt_st.mode != pmr_pkg::PMR_PDOWN);
        nxt_st.pin.program_store_strobe = (nxt_st.mode != pmr_pkg::PMR_PDOWN);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_ff          <= '0;
            st_ff.mode     <= pmr_pkg::PMR_RESET;
            st_ff.por_cnt  <= POR_CYCLES_P;
            st_ff.core_reset <= 1'b1;
            st_ff.clk      <= 5'h1F;
            st_ff.clk.core_clk_en <= 1'b0;
            st_ff.pin      <= 4'hF;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mode            = st_ff.mode;
    assign clk_ctl         = st_ff.clk;
    assign pin_ctl         = st_ff.pin;
    assign core_reset      = st_ff.core_reset;
    assign pll_control_reg = {1'b0, st_ff.pll_locked, 6'h00};
    assign wake_pulse      = st_ff.wake_pulse;
endmodule // pmr_sequencer

// File: dv/pmr_sequencer_monitor.sv
// checker for the power mode and reset sequencer
module pmr_sequencer_monitor (
    input wire logic              mclk,
    input wire logic              reset,
    input wire logic              idle_req,
    input wire logic              powerdown_req,
    input wire logic              oscillator_powerdown_bit,
    input wire logic              any_enabled_irq,
    input wire logic              interval_counter_irq,
    input wire logic              interval_counter_enable,
    input wire logic [1:0]        mode,
    input wire pmr_pkg::pmr_clk_t clk_ctl,
    input wire pmr_pkg::pmr_pin_t pin_ctl,
    input wire logic              wake_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic nrm = mode == pmr_pkg::PMR_NORMAL;
    wire logic idl = mode == pmr_pkg::PMR_IDLE;
    wire logic pdn = mode == pmr_pkg::PMR_PDOWN;
    sequence s_woke; nrm && wake_pulse ##1 !wake_pulse; endsequence
    AST_IDLE_ENTRY: assert property (nrm && idle_req && !powerdown_req |=> idl) else $error("idle missed");
    AST_PD_ENTRY: assert property (nrm && powerdown_req |=> pdn) else $error("power-down missed");
    AST_IDLE_CLK: assert property (idl |-> !clk_ctl.core_clk_en && clk_ctl.osc_en && clk_ctl.periph_clk_en)
        else $error("idle clocks wrong");
    AST_IDLE_PIN: assert property (idl |-> pin_ctl.ale && pin_ctl.program_store_strobe && pin_ctl.hold_ports)
        else $error("idle strobes wrong");
    AST_IDLE_WAKE: assert property (idl && any_enabled_irq |=> s_woke) else $error("idle wake missed");
    AST_PD_CLK: assert property (pdn |-> !clk_ctl.core_clk_en && !clk_ctl.pll_en && !clk_ctl.periph_clk_en
        && clk_ctl.osc_en != oscillator_powerdown_bit) else $error("power-down clocks wrong");
    AST_PD_PIN: assert property (pdn |-> !pin_ctl.ale && !pin_ctl.program_store_strobe && !pin_ctl.dac_oe)
        else $error("power-down pins wrong");
    AST_TIC_WAKE: assert property (pdn && interval_counter_irq && interval_counter_enable
        && !oscillator_powerdown_bit |=> s_woke) else $error("counter wake missed");
endmodule // pmr_sequencer_monitor

bind pmr_sequencer pmr_sequencer_monitor u_mon (.mclk, .reset, .idle_req, .powerdown_req, .oscillator_powerdown_bit,
    .any_enabled_irq, .interval_counter_irq, .interval_counter_enable, .mode, .clk_ctl, .pin_ctl, .wake_pulse);

// File: dv/tb_pmr_sequencer.sv
// self-checking bench for the power mode and reset sequencer
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb_pmr_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, reset, supply_ok, reset_pin, idle_req, powerdown_req, oscillator_powerdown_bit, serial_wake_enable;
    logic ext_int_zero_wake_enable, any_enabled_irq, interval_counter_irq, interval_counter_enable, spi_irq_enabled;
    logic external_interrupt_zero_enabled, core_reset, wake_pulse;
    logic [1:0]        mode;
    logic [7:0]        pll_control_reg;
    pmr_pkg::pmr_clk_t clk_ctl;
    pmr_pkg::pmr_pin_t pin_ctl;
    int                fail_count = 0;
    int                checked = 0;
    int                cyc = 0;
    int                n;
    pmr_sequencer #(.POR_CYCLES_P(32'h14), .PLL_CYCLES_P(32'h0A), .OSC_CYCLES_P(32'h1E)) dut (.mclk, .reset,
        .supply_ok, .reset_pin, .idle_req, .powerdown_req, .oscillator_powerdown_bit, .serial_wake_enable,
        .ext_int_zero_wake_enable, .any_enabled_irq, .interval_counter_irq, .interval_counter_enable,
        .spi_irq_enabled, .external_interrupt_zero_enabled, .mode, .clk_ctl, .pin_ctl, .core_reset,
        .pll_control_reg, .wake_pulse);
    task tick; @(posedge mclk); #2; endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task go(input logic i, input logic p, input logic [1:0] m);
        {idle_req, powerdown_req} = {i, p};
        tick;
        {idle_req, powerdown_req} = 2'h0;
        `CHK("mode", m, mode)
    endtask
    task wake(input int k, input logic [1:0] m);
        {any_enabled_irq, interval_counter_irq, spi_irq_enabled, external_interrupt_zero_enabled} = 4'h8 >> k;
        tick;
        {any_enabled_irq, interval_counter_irq, spi_irq_enabled, external_interrupt_zero_enabled} = 4'h0;
        `CHK("wake_mode", m, mode)
        if (m == pmr_pkg::PMR_NORMAL) `CHK("wake_pulse", 1'b1, wake_pulse)
    endtask
    task lock(input int t);
        `CHK("lock_low", 1'b0, pll_control_reg[6])
        n = 0;
        while (pll_control_reg[6] !== 1'b1 && n < 200) begin tick; n++; end
        `CHK("lock_time", 1'b1, n >= t - 1 && n <= t + 2)
    endtask
    initial begin mclk = 0; forever #12.5 mclk = ~mclk; end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin fail_count++; tally_and_finish(); end
    end
    initial begin
        {reset_pin, idle_req, powerdown_req, oscillator_powerdown_bit, any_enabled_irq, interval_counter_irq} = 6'h0;
        {spi_irq_enabled, external_interrupt_zero_enabled, serial_wake_enable, ext_int_zero_wake_enable} = 4'h0;
        {reset, supply_ok, interval_counter_enable} = 3'h7;
        repeat (5) tick;
        reset = 0;
        n = 0;
        while (core_reset !== 1'b0 && n < 100) begin tick; n++; end
        `CHK("por_time", 1'b1, n >= 20 && n <= 24)
        go(1, 0, pmr_pkg::PMR_IDLE);
        go(0, 1, pmr_pkg::PMR_IDLE);
        wake(0, pmr_pkg::PMR_NORMAL);
        for (int k = 1; k < 4; k++) begin
            go(0, 1, pmr_pkg::PMR_PDOWN);
            `CHK("tic_on", 1'b1, clk_ctl.interval_counter_en)
            {interval_counter_enable, serial_wake_enable, ext_int_zero_wake_enable} = 3'h0;
            wake(k, pmr_pkg::PMR_PDOWN);
            {interval_counter_enable, serial_wake_enable, ext_int_zero_wake_enable} = 3'h7;
            wake(k, pmr_pkg::PMR_NORMAL);
            lock(10);
        end
        oscillator_powerdown_bit = 1;
        go(1, 1, pmr_pkg::PMR_PDOWN);
        `CHK("osc_en", 1'b0, clk_ctl.osc_en)
        `CHK("tic_off", 1'b0, clk_ctl.interval_counter_en)
        wake(1, pmr_pkg::PMR_PDOWN);
        wake(3, pmr_pkg::PMR_NORMAL);
        lock(40);
        go(0, 1, pmr_pkg::PMR_PDOWN);
        reset_pin = 1;
        repeat (4) tick;
        `CHK("pin_reset", 1'b1, core_reset)
        reset_pin = 0;
        n = 0;
        while (mode !== pmr_pkg::PMR_NORMAL && n < 10) begin tick; n++; end
        `CHK("pin_release", 1'b0, core_reset)
        supply_ok = 0;
        repeat (4) tick;
        `CHK("supply_low", 1'b1, core_reset)
        tally_and_finish();
    end
endmodule // tb_pmr_sequencer
